// ---- rtl/usb_irq_map.vh ----
/*
 * register map, reset values and bit layouts of the usb interrupt router.
 * assumes a 32-bit apb slave with each register in one aligned word,
 * 8-bit data in the low byte and the upper bits reading as zero.
 */
`ifndef USB_IRQ_MAP_VH
`define USB_IRQ_MAP_VH

// byte offsets on the apb bus
`define OFS_LINE_SELECT_0 8'h00
`define OFS_LINE_SELECT_1 8'h04
`define OFS_LINE_SELECT_2 8'h08
`define OFS_GATE_0 8'h0c
`define OFS_GATE_1 8'h10
`define OFS_GATE_2 8'h14
`define OFS_FLAGS_0 8'h18
`define OFS_FLAGS_1 8'h1c
`define OFS_FLAGS_2 8'h20
`define OFS_IRQ_STATUS 8'h24
`define OFS_IRQ_MASK 8'h28

// reset values
`define RST_LINE_SELECT_0 8'h00
`define RST_LINE_SELECT_1 8'h07
`define RST_LINE_SELECT_2 8'h1f
`define RST_GATE 8'h00
`define RST_FLAGS 8'h00
`define RST_IRQ 3'h0

// writable bits of each group (others reserved)
`define WMASK_GROUP_0 8'hff
`define WMASK_GROUP_1 8'h07
`define WMASK_GROUP_2 8'h1b
`define WMASK_GATE_2 8'h9b
// select 2 bit 2 is reserved and always reads one
`define FIXED_ONE_SELECT_2 8'h04

// group 0 bit positions
`define BIT_BUS_RESET 7
`define BIT_BULK_OUT_FULL 6
`define BIT_BULK_IN_REQ 5
`define BIT_BULK_IN_EMPTY 4
`define BIT_SETUP_RX 3
`define BIT_CTRL_OUT_RX 2
`define BIT_CTRL_IN_REQ 1
`define BIT_CTRL_IN_SENT 0
// group 1 bit positions
`define BIT_INT_IN_REQ 2
`define BIT_INT_IN_SENT 1
`define BIT_CABLE_CHANGE 0
// group 2 bit positions
`define BIT_STANDBY_RESUME 7
`define BIT_SUSPEND_CHANGE 4
`define BIT_EP_INFO_LOADED 3
`define BIT_SET_CONFIG 1
`define BIT_SET_IFACE 0

// block status bits (write one to clear)
`define ST_LINE_A_RISE 0
`define ST_LINE_B_RISE 1
`define ST_RESERVED_WRITE 2

`endif

// ---- rtl/irq_flag_bank.v ----
/*
 * one group of event flags with its routing and gating.
 * assumes set pulses and the flag-clear write come from logic on pclk.
 */
`timescale 1ns/1ns
module irq_flag_bank #(
   parameter WIDTH = 8,
   parameter [7:0] MASK = 8'hff
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   // source events and software clear
   input wire [WIDTH-1:0] set_evt,
   input wire clear_wr,
   input wire [WIDTH-1:0] clear_data,
   // routing and gating
   input wire [WIDTH-1:0] select,
   input wire [WIDTH-1:0] gate,
   // results
   output wire [WIDTH-1:0] flags,
   output wire req_a,
   output wire req_b
);
   reg [WIDTH-1:0] flags_reg;
   wire [WIDTH-1:0] live;

   genvar i;
   generate
      for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
         // set beats a clear landing in the same cycle
         always @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               flags_reg[i] <= 1'b0;
            end else if (clk_en && MASK[i]) begin
               if (set_evt[i]) begin
                  flags_reg[i] <= 1'b1;
               end else if (clear_wr && !clear_data[i]) begin
                  flags_reg[i] <= 1'b0;
               end
            end
         end
         // flag counts only while its gate is open
         assign live[i] = flags_reg[i] & gate[i];
      end
   endgenerate

   assign flags = flags_reg;
   // select bit 0 picks line a, 1 picks line b
   assign req_a = |(live & ~select);
   assign req_b = |(live & select);
endmodule

// ---- rtl/usb_function_irq_routing.v ----
/*
 * usb function interrupt router: event flags, per-source line select,
 * per-source gating, two request lines to the cpu interrupt controller,
 * and an apb register file with a summary interrupt.
 * assumes event inputs are one-cycle pulses from logic on pclk and an
 * apb3 master with 32-bit data; pready follows clk_en.
 */
`timescale 1ns/1ns
`include "usb_irq_map.vh"
module usb_function_irq_routing #(
   parameter ADDR_W = 8
) (
   // clock, reset, enable
   input wire pclk,
   input wire presetn,
   input wire clk_en,
   // apb slave
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output wire pready,
   output reg pslverr,
   // group 0 source events
   input wire bus_reset_event,
   input wire bulk_out_buffer_full,
   input wire bulk_in_request,
   input wire bulk_in_buffer_empty,
   input wire setup_received,
   input wire control_out_received,
   input wire control_in_request,
   input wire control_in_sent,
   // group 1 source events
   input wire interrupt_in_request,
   input wire interrupt_in_sent,
   input wire cable_attach_change,
   // group 2 source events
   input wire suspend_resume_change,
   input wire endpoint_info_loaded,
   input wire set_configuration_seen,
   input wire set_interface_seen,
   // to the cpu interrupt controller
   output reg usb_request_line_a,
   output reg usb_request_line_b,
   output wire standby_resume_enable,
   output wire irq
);
   // register file state
   reg [7:0] line_select_0_reg;
   reg [7:0] line_select_1_reg;
   reg [7:0] line_select_2_reg;
   reg [7:0] gate_0_reg;
   reg [7:0] gate_1_reg;
   reg [7:0] gate_2_reg;
   reg [2:0] irq_status_reg;
   reg [2:0] irq_mask_reg;
   reg [2:0] irq_status_next;
   reg [31:0] rdata_next;
   reg addr_ok;

   wire [7:0] set_0;
   wire [7:0] set_1;
   wire [7:0] set_2;
   wire [7:0] flags_0;
   wire [7:0] flags_1;
   wire [7:0] flags_2;
   wire [2:0] req_a;
   wire [2:0] req_b;
   wire line_a_next;
   wire line_b_next;
   wire setup_ph;
   wire wr;
   wire [7:0] wd;
   wire wr_sel_0;
   wire wr_sel_1;
   wire wr_sel_2;
   wire wr_gate_0;
   wire wr_gate_1;
   wire wr_gate_2;
   wire wr_flags_0;
   wire wr_flags_1;
   wire wr_flags_2;
   wire wr_status;
   wire wr_mask;
   wire bad_reserved;

   // apb strobes; a frozen block holds the transfer in its access phase
   assign pready = clk_en;
   assign setup_ph = psel & ~penable;
   assign wr = psel & penable & pwrite & clk_en & addr_ok;
   assign wd = pwdata[7:0];

   assign wr_sel_0 = wr && (paddr == `OFS_LINE_SELECT_0);
   assign wr_sel_1 = wr && (paddr == `OFS_LINE_SELECT_1);
   assign wr_sel_2 = wr && (paddr == `OFS_LINE_SELECT_2);
   assign wr_gate_0 = wr && (paddr == `OFS_GATE_0);
   assign wr_gate_1 = wr && (paddr == `OFS_GATE_1);
   assign wr_gate_2 = wr && (paddr == `OFS_GATE_2);
   assign wr_flags_0 = wr && (paddr == `OFS_FLAGS_0);
   assign wr_flags_1 = wr && (paddr == `OFS_FLAGS_1);
   assign wr_flags_2 = wr && (paddr == `OFS_FLAGS_2);
   assign wr_status = wr && (paddr == `OFS_IRQ_STATUS);
   assign wr_mask = wr && (paddr == `OFS_IRQ_MASK);

   // address decode for the answer
   always @* begin
      case (paddr)
         `OFS_LINE_SELECT_0, `OFS_LINE_SELECT_1, `OFS_LINE_SELECT_2,
         `OFS_GATE_0, `OFS_GATE_1, `OFS_GATE_2,
         `OFS_FLAGS_0, `OFS_FLAGS_1, `OFS_FLAGS_2,
         `OFS_IRQ_STATUS, `OFS_IRQ_MASK: addr_ok = 1'b1;
         default: addr_ok = 1'b0;
      endcase
   end

   // software breaking the reserved-bit convention in a select or gate write is flagged, not obeyed
   assign bad_reserved =
      ((wr_sel_1 | wr_gate_1) && ((wd & ~`WMASK_GROUP_1) != 8'h00)) ||
      (wr_sel_2 && ((wd & ~(`WMASK_GROUP_2 | `FIXED_ONE_SELECT_2)) != 8'h00)) ||
      (wr_sel_2 && !wd[2]) ||
      (wr_gate_2 && ((wd & ~`WMASK_GATE_2) != 8'h00));

   // source events packed into their flag positions
   assign set_0 = {bus_reset_event, bulk_out_buffer_full, bulk_in_request,
                   bulk_in_buffer_empty, setup_received, control_out_received,
                   control_in_request, control_in_sent};
   assign set_1 = {5'h00, interrupt_in_request, interrupt_in_sent,
                   cable_attach_change};
   assign set_2 = {3'h0, suspend_resume_change, endpoint_info_loaded, 1'b0,
                   set_configuration_seen, set_interface_seen};

   // select registers; only documented bits are stored
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         line_select_0_reg <= `RST_LINE_SELECT_0;
         line_select_1_reg <= `RST_LINE_SELECT_1;
         line_select_2_reg <= `RST_LINE_SELECT_2;
      end else if (clk_en) begin
         if (wr_sel_0) begin
            line_select_0_reg <= wd & `WMASK_GROUP_0;
         end
         if (wr_sel_1) begin
            line_select_1_reg <= wd & `WMASK_GROUP_1;
         end
         if (wr_sel_2) begin
            // bit 2 stays one whatever is written
            line_select_2_reg <= (wd & `WMASK_GROUP_2) | `FIXED_ONE_SELECT_2;
         end
      end
   end

   // gate registers, all closed after reset
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_0_reg <= `RST_GATE;
         gate_1_reg <= `RST_GATE;
         gate_2_reg <= `RST_GATE;
      end else if (clk_en) begin
         if (wr_gate_0) begin
            gate_0_reg <= wd & `WMASK_GROUP_0;
         end
         if (wr_gate_1) begin
            gate_1_reg <= wd & `WMASK_GROUP_1;
         end
         if (wr_gate_2) begin
            gate_2_reg <= wd & `WMASK_GATE_2;
         end
      end
   end

   // bit 7 of gate 2 only arms resume wake-up from standby
   assign standby_resume_enable = gate_2_reg[`BIT_STANDBY_RESUME];

   // the three flag groups, each with its own select and gate
   irq_flag_bank #(.WIDTH(8), .MASK(`WMASK_GROUP_0)) u_bank_0 (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .set_evt(set_0),
      .clear_wr(wr_flags_0),
      .clear_data(wd),
      .select(line_select_0_reg),
      .gate(gate_0_reg),
      .flags(flags_0),
      .req_a(req_a[0]),
      .req_b(req_b[0])
   );

   irq_flag_bank #(.WIDTH(8), .MASK(`WMASK_GROUP_1)) u_bank_1 (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .set_evt(set_1),
      .clear_wr(wr_flags_1),
      .clear_data(wd),
      .select(line_select_1_reg),
      .gate(gate_1_reg),
      .flags(flags_1),
      .req_a(req_a[1]),
      .req_b(req_b[1])
   );

   // gate bit 7 is not a source gate, so it is masked off here
   irq_flag_bank #(.WIDTH(8), .MASK(`WMASK_GROUP_2)) u_bank_2 (
      .pclk(pclk),
      .presetn(presetn),
      .clk_en(clk_en),
      .set_evt(set_2),
      .clear_wr(wr_flags_2),
      .clear_data(wd),
      .select(line_select_2_reg),
      .gate(gate_2_reg & `WMASK_GROUP_2),
      .flags(flags_2),
      .req_a(req_a[2]),
      .req_b(req_b[2])
   );

   // request lines registered for a glitch-free edge to the controller
   assign line_a_next = |req_a;
   assign line_b_next = |req_b;

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         usb_request_line_a <= 1'b0;
         usb_request_line_b <= 1'b0;
      end else if (clk_en) begin
         usb_request_line_a <= line_a_next;
         usb_request_line_b <= line_b_next;
      end
   end

   // sticky status: a new event wins over a same-cycle clear
   always @* begin
      irq_status_next = irq_status_reg;
      if (wr_status) begin
         irq_status_next = irq_status_reg & ~wd[2:0];
      end
      if (line_a_next && !usb_request_line_a) begin
         irq_status_next[`ST_LINE_A_RISE] = 1'b1;
      end
      if (line_b_next && !usb_request_line_b) begin
         irq_status_next[`ST_LINE_B_RISE] = 1'b1;
      end
      if (bad_reserved) begin
         irq_status_next[`ST_RESERVED_WRITE] = 1'b1;
      end
   end

   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         irq_status_reg <= `RST_IRQ;
         irq_mask_reg <= `RST_IRQ;
      end else if (clk_en) begin
         irq_status_reg <= irq_status_next;
         if (wr_mask) begin
            irq_mask_reg <= wd[2:0];
         end
      end
   end

   assign irq = |(irq_status_reg & irq_mask_reg);

   // read mux; unstored bits read zero except the fixed one
   always @* begin
      case (paddr)
         `OFS_LINE_SELECT_0: rdata_next = {24'h000000, line_select_0_reg};
         `OFS_LINE_SELECT_1: rdata_next = {24'h000000, line_select_1_reg};
         `OFS_LINE_SELECT_2: rdata_next = {24'h000000, line_select_2_reg};
         `OFS_GATE_0: rdata_next = {24'h000000, gate_0_reg};
         `OFS_GATE_1: rdata_next = {24'h000000, gate_1_reg};
         `OFS_GATE_2: rdata_next = {24'h000000, gate_2_reg};
         `OFS_FLAGS_0: rdata_next = {24'h000000, flags_0};
         `OFS_FLAGS_1: rdata_next = {24'h000000, flags_1};
         `OFS_FLAGS_2: rdata_next = {24'h000000, flags_2};
         `OFS_IRQ_STATUS: rdata_next = {29'h0, irq_status_reg};
         `OFS_IRQ_MASK: rdata_next = {29'h0, irq_mask_reg};
         default: rdata_next = 32'h00000000;
      endcase
   end

   // answer captured in the setup cycle, so it stands through the access phase
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h00000000;
         pslverr <= 1'b0;
      end else if (clk_en && setup_ph) begin
         prdata <= pwrite ? 32'h00000000 : rdata_next;
         pslverr <= ~addr_ok;
      end
   end
endmodule

// ---- testbench/usb_irq_routing_chk.sv ----
/*
 * port assertions for the usb interrupt router, with shadow copies of
 * the select and gate registers taken from apb writes.
 * assumes the byte offsets and reset values of the register map.
 */
`timescale 1ns/1ns
module usb_irq_routing_chk #(
   parameter ADDR_W = 8
) (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // apb
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [ADDR_W-1:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire pready,
   // request outputs
   input wire usb_request_line_a,
   input wire usb_request_line_b,
   input wire irq
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   reg [7:0] s0_reg, s1_reg, s2_reg, g0_reg, g1_reg, g2_reg;
   wire rdo = psel && penable && pready && !pwrite;
   wire wro = psel && penable && pready && pwrite;
   // only live bits count; reserved ones are ignored by the block
   wire gz = ~|{g0_reg, g1_reg[2:0], g2_reg[4:3], g2_reg[1:0]};
   wire s_one = &{s0_reg, s1_reg[2:0], s2_reg[4:3], s2_reg[1:0]};
   wire s_zero = ~|{s0_reg, s1_reg[2:0], s2_reg[4:3], s2_reg[1:0]};
   // shadows follow every completed write
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         s0_reg <= 8'h00;
         s1_reg <= 8'h07;
         s2_reg <= 8'h1f;
         g0_reg <= 8'h00;
         g1_reg <= 8'h00;
         g2_reg <= 8'h00;
      end else if (wro) begin
         case (paddr)
            8'h00: s0_reg <= pwdata[7:0];
            8'h04: s1_reg <= pwdata[7:0];
            8'h08: s2_reg <= pwdata[7:0];
            8'h0c: g0_reg <= pwdata[7:0];
            8'h10: g1_reg <= pwdata[7:0];
            8'h14: g2_reg <= pwdata[7:0];
            default: ;
         endcase
      end
   end
   upper_zero_a: assert property (rdo |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   sel1_rsvd_a: assert property (rdo && paddr == 8'h04 |-> prdata[7:3] == 5'h0)
      else $error("select 1 reserved bits set");
   sel2_fixed_a: assert property (rdo && paddr == 8'h08 |-> prdata[7:5] == 3'h0 && prdata[2])
      else $error("select 2 fixed bits wrong");
   gate1_rsvd_a: assert property (rdo && paddr == 8'h10 |-> prdata[7:3] == 5'h0)
      else $error("gate 1 reserved bits set");
   gate2_rsvd_a: assert property (rdo && paddr == 8'h14 |-> prdata[6:5] == 2'h0 && !prdata[2])
      else $error("gate 2 reserved bits set");
   gate_shut_a: assert property (gz && $past(gz) |-> !usb_request_line_a && !usb_request_line_b)
      else $error("request with all gates closed");
   route_b_a: assert property (s_one && $past(s_one) |-> !usb_request_line_a)
      else $error("line a used with all selects one");
   route_a_a: assert property (s_zero && $past(s_zero) |-> !usb_request_line_b)
      else $error("line b used with all selects zero");
   mask_off_a: assert property (wro && paddr == 8'h28 && pwdata[2:0] == 3'h0 |=> !irq)
      else $error("irq high with mask cleared");
endmodule
bind usb_function_irq_routing usb_irq_routing_chk #(.ADDR_W(ADDR_W)) u_chk (.pclk(pclk),
   .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
   .pwdata(pwdata), .prdata(prdata), .pready(pready), .usb_request_line_a(usb_request_line_a),
   .usb_request_line_b(usb_request_line_b), .irq(irq));

// ---- testbench/cpu_irq_model.sv ----
/*
 * cpu interrupt controller stand-in: counts requests on both lines.
 * assumes level request lines sampled on pclk.
 */
`timescale 1ns/1ns
module cpu_irq_model (
   // clock and reset
   input wire pclk,
   input wire presetn,
   // request lines
   input wire line_a,
   input wire line_b,
   // request counts
   output reg [15:0] count_a_reg,
   output reg [15:0] count_b_reg
);
   reg a_reg, b_reg;
   // a held level is one request, so only rises are counted
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         a_reg <= 1'b0;
         b_reg <= 1'b0;
         count_a_reg <= 16'h0;
         count_b_reg <= 16'h0;
      end else begin
         a_reg <= line_a;
         b_reg <= line_b;
         count_a_reg <= count_a_reg + {15'h0, line_a & ~a_reg};
         count_b_reg <= count_b_reg + {15'h0, line_b & ~b_reg};
      end
   end
endmodule

// ---- testbench/usb_function_irq_routing_test.sv ----
/*
 * self-checking bench: apb master, random events, line model.
 * assumes the router, checker and cpu model are compiled first.
 */
`timescale 1ns/1ns
module usb_function_irq_routing_test;
   reg pclk, presetn, psel, penable, pwrite, err, ea, eb, ce;
   reg [7:0] paddr;
   reg [31:0] pwdata, rd, seed, w;
   reg [14:0] ev, e;
   reg [7:0] s [0:2];
   reg [7:0] g [0:2];
   reg [7:0] f [0:2];
   wire [31:0] prdata;
   wire pready, pslverr, la, lb, sre, irq;
   wire [15:0] na, nb;
   integer fails, checked, cyc, i, j, n;
   usb_function_irq_routing u_usb_function_irq_routing (.pclk(pclk), .presetn(presetn),
      .clk_en(ce), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
      .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus_reset_event(ev[7]), .bulk_out_buffer_full(ev[6]), .bulk_in_request(ev[5]),
      .bulk_in_buffer_empty(ev[4]), .setup_received(ev[3]), .control_out_received(ev[2]),
      .control_in_request(ev[1]), .control_in_sent(ev[0]), .interrupt_in_request(ev[10]),
      .interrupt_in_sent(ev[9]), .cable_attach_change(ev[8]), .suspend_resume_change(ev[14]),
      .endpoint_info_loaded(ev[13]), .set_configuration_seen(ev[12]),
      .set_interface_seen(ev[11]), .usb_request_line_a(la), .usb_request_line_b(lb),
      .standby_resume_enable(sre), .irq(irq));
   cpu_irq_model u_cpu_irq_model (.pclk(pclk), .presetn(presetn), .line_a(la), .line_b(lb),
      .count_a_reg(na), .count_b_reg(nb));
   function [31:0] rnd;
      begin
         seed = seed ^ (seed << 13);
         seed = seed ^ (seed >> 17);
         seed = seed ^ (seed << 5);
         rnd = seed;
      end
   endfunction
   // first two passes force all ones, then all zeros
   function [31:0] rv(input integer k);
      rv = k > 1 ? rnd() : (k == 0 ? 32'hffffffff : 32'h0);
   endfunction
   function [7:0] lm(input integer k);
      lm = k == 0 ? 8'hff : (k == 1 ? 8'h07 : 8'h1b);
   endfunction
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            fails = fails + 1;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
         end
      end
   endtask
   // one transfer, then an idle edge so psel is never driven twice at once
   task apb(input wr, input [7:0] a, input [31:0] d);
      begin
         psel <= 1'b1;
         pwrite <= wr;
         paddr <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         @(posedge pclk);
         while (pready !== 1'b1) @(posedge pclk);
         rd = prdata;
         err = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
         @(posedge pclk);
      end
   endtask
   task look;
      begin
         @(negedge pclk);
         ea = |(f[0] & g[0] & ~s[0] | f[1] & g[1] & ~s[1] | f[2] & g[2] & ~s[2] & 8'h1b);
         eb = |(f[0] & g[0] & s[0] | f[1] & g[1] & s[1] | f[2] & g[2] & s[2] & 8'h1b);
         chk({la, lb, sre}, {ea, eb, g[2][7]});
         @(posedge pclk);
      end
   endtask
   task ick(input v);
      begin
         @(negedge pclk);
         chk(irq, v);
         @(posedge pclk);
      end
   endtask
   task wrap_up;
      begin
         $display("comparisons %0d mismatches %0d", checked, fails);
         if (fails == 0 && checked > 0)
            $display("Simulation passed");
         else
            $display("Simulation failed");
         $finish;
      end
   endtask
   // clock, 100 ns period
   initial begin
      pclk = 1'b0;
      forever #50 pclk = ~pclk;
   end
   // hang guard, far above the few thousand cycles the run needs
   always @(posedge pclk) begin
      cyc = cyc + 1;
      if (cyc > 20000) begin
         fails = fails + 1;
         wrap_up;
      end
   end
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, ev} = 0;
      {fails, checked, cyc} = 0;
      ce = 1'b1;
      seed = 32'h23;
      for (j = 0; j < 3; j = j + 1) begin
         f[j] = 0;
         g[j] = 0;
      end
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      for (i = 0; i < 11; i = i + 1) begin
         apb(0, 4 * i, 0);
         chk(rd, i == 1 ? 8'h07 : (i == 2 ? 8'h1f : 8'h00));
      end
      apb(0, 8'h2c, 0);
      chk({31'h0, err}, 32'h1);
      chk(rd, 32'h0);
      for (n = 0; n < 40; n = n + 1) begin
         for (j = 0; j < 3; j = j + 1) begin
            s[j] = rv(n) & lm(j) | (j == 2 ? 8'h04 : 8'h00);
            g[j] = rv(n) & (j == 2 ? 8'h9b : lm(j));
            apb(1, 4 * j, s[j]);
            apb(1, 12 + 4 * j, g[j]);
         end
         e = rnd();
         ev <= e;
         @(posedge pclk);
         ev <= 0;
         @(posedge pclk);
         f[0] = f[0] | e[7:0];
         f[1] = f[1] | e[10:8];
         f[2] = f[2] | {3'b0, e[14:13], 1'b0, e[12:11]};
         look;
         for (j = 0; j < 3; j = j + 1) begin
            apb(0, 4 * j, 0);
            chk(rd, s[j]);
            apb(0, 12 + 4 * j, 0);
            chk(rd, g[j]);
            apb(0, 24 + 4 * j, 0);
            chk(rd, f[j]);
            w = rnd();
            apb(1, 24 + 4 * j, w);
            f[j] = f[j] & w[7:0];
         end
         look;
      end
      apb(1, 8'h24, 7);
      apb(1, 8'h28, 4);
      ick(0);
      apb(1, 8'h04, 8'hff);
      ick(1);
      apb(0, 8'h04, 0);
      chk(rd, 8'h07);
      apb(1, 8'h08, 0);
      apb(0, 8'h08, 0);
      chk(rd, 8'h04);
      apb(1, 8'h28, 0);
      ick(0);
      apb(1, 8'h28, 4);
      ick(1);
      apb(1, 8'h24, 4);
      ick(0);
      // frozen block: events are lost and pready stays low
      ce <= 1'b0;
      ev <= 15'h00ff;
      @(posedge pclk);
      ev <= 0;
      @(negedge pclk);
      chk(pready, 0);
      @(posedge pclk);
      ce <= 1'b1;
      apb(0, 8'h18, 0);
      chk(rd, f[0]);
      chk(na != 0 && nb != 0, 1);
      wrap_up;
   end
endmodule
